// file: fci_indicator.sv
`timescale 1ns/100ps
`include "fci_cfg.svh"
// Functional notes
// - on error, status goes red and error number shows on the four lines together
// - codes 1-5 stay latched until a fresh reset
// - codes 7-15 shown one minute, then cleared automatically
// - in configuration mode indications carry no fault meaning
// - serial variant: 1 init, 2 nvm, 3 stack, 4 fieldbus hw, 5 protocol; 0, 6 reserved
// - serial variant: 7 tx overflow, 8 rx overflow, 9 rx timeout, 10 tx fail
// - serial variant: 11 parity/frame, 12 address, 13 fieldbus config, 14 general, 15 internal
// - script variant: 1-5 hw, nvm, memory, fieldbus hw/id, script; 12,13,15 reserved
// - error number lines flash while status is steadily red
// - without error the lines show the current serial bus address
// warning hold time in clock cycles; a short run may lower it
module fci_indicator #(
  parameter logic [`FCI_TMR_W-1:0] WARN_CYCLES = `FCI_TMR_W'(`FCI_WARN_CYCLES)
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic script_variant_i,
  input wire logic config_mode_i,
  input wire logic err_valid_i,
  input wire logic [3:0] err_code_i,
  input wire logic [3:0] bus_addr_i,
  output logic status_red_o,
  output logic fault_valid_o,
  output logic weight_eight_indicator_o,
  output logic weight_four_indicator_o,
  output logic weight_two_indicator_o,
  output logic weight_one_indicator_o
);
  // ----------------------------------------------------------------
  // code classification
  // ----------------------------------------------------------------
  logic [3:0] code_q;
  logic [3:0] code_d;
  fci_pkg::fci_state_t state_q;
  fci_pkg::fci_state_t state_d;
  logic phase_q;
  logic red_q;
  logic [3:0] lines_q;
  logic [3:0] lines_d;
  logic fv_q;
  logic warn_busy;
  logic warn_done;
  logic flash_busy;
  logic flash_done;

  wire rsvd_w = (err_code_i == 4'h0) || (err_code_i == 4'h6) ||
    (script_variant_i && ((err_code_i == 4'hc) || (err_code_i == 4'hd) ||
    (err_code_i == 4'hf)));
  wire acc_w = err_valid_i && !rsvd_w;
  wire is_serious_w = (err_code_i >= `FCI_SERIOUS_MIN) && (err_code_i <= `FCI_SERIOUS_MAX);
  wire is_warn_w = (err_code_i >= `FCI_WARN_MIN) && (err_code_i <= `FCI_WARN_MAX);
  wire new_serious_w = acc_w && is_serious_w && (state_q != fci_pkg::FCI_SERIOUS);
  wire new_warn_w = acc_w && is_warn_w && (state_q != fci_pkg::FCI_SERIOUS);
  wire showing_w = (state_q != fci_pkg::FCI_IDLE);

  // ----------------------------------------------------------------
  // display state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    code_d = code_q;
    unique case (state_q)
      fci_pkg::FCI_IDLE,
      fci_pkg::FCI_WARN: begin
        if (new_serious_w) begin
          state_d = fci_pkg::FCI_SERIOUS;
          code_d = err_code_i;
        end else if (new_warn_w) begin
          state_d = fci_pkg::FCI_WARN;
          code_d = err_code_i;
        end else if (state_q == fci_pkg::FCI_WARN && warn_done) begin
          state_d = fci_pkg::FCI_IDLE;
          code_d = 4'h0;
        end
      end
      fci_pkg::FCI_SERIOUS: begin
        state_d = fci_pkg::FCI_SERIOUS;
      end
      default: begin
        state_d = fci_pkg::FCI_IDLE;
        code_d = 4'h0;
      end
    endcase
  end

  fci_timer u_warn_tmr (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .start_i(new_warn_w),
    .stop_i(new_serious_w),
    .load_i(WARN_CYCLES),
    .busy_o(warn_busy),
    .done_o(warn_done)
  );

  // free-running flash timebase, reloaded once it has run out
  // done is not fed back into start: that would be a combinational loop
  fci_timer u_flash_tmr (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .start_i(!flash_busy),
    .stop_i(1'b0),
    .load_i(`FCI_TMR_W'(`FCI_FLASH_CYCLES)),
    .busy_o(flash_busy),
    .done_o(flash_done)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire next_show_w = (state_d != fci_pkg::FCI_IDLE);
  wire phase_d = next_show_w && !showing_w ? 1'b1 : (flash_done ? !phase_q : phase_q);
  // lines flash code while red, else show address
  assign lines_d = next_show_w ? (phase_d ? code_d : 4'h0) : bus_addr_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= fci_pkg::FCI_IDLE;
      code_q <= 4'h0;
      phase_q <= 1'b0;
      red_q <= 1'b0;
      lines_q <= 4'h0;
      fv_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      code_q <= code_d;
      phase_q <= phase_d;
      red_q <= next_show_w;
      lines_q <= lines_d;
      fv_q <= next_show_w && !config_mode_i;
    end
  end

  assign status_red_o = red_q;
  assign fault_valid_o = fv_q;
  assign weight_eight_indicator_o = lines_q[3];
  assign weight_four_indicator_o = lines_q[2];
  assign weight_two_indicator_o = lines_q[1];
  assign weight_one_indicator_o = lines_q[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_serious_in;
    ce_i && acc_w && is_serious_w;
  endsequence

  chk_red_follows_err: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && acc_w && (is_serious_w || state_q != fci_pkg::FCI_SERIOUS) |=> status_red_o)
    else $error("status not red after error");
  chk_serious_latched: assert property (@(posedge clk_i) disable iff (srst_i)
    s_serious_in |=> (state_q == fci_pkg::FCI_SERIOUS) ##1 (state_q == fci_pkg::FCI_SERIOUS))
    else $error("serious error not latched");
  chk_serious_holds: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == fci_pkg::FCI_SERIOUS |=> state_q == fci_pkg::FCI_SERIOUS && $stable(code_q))
    else $error("serious code changed");
  chk_warn_expiry: assert property (@(posedge clk_i) disable iff (srst_i)
    state_q == fci_pkg::FCI_WARN && warn_done && !acc_w |=> state_q == fci_pkg::FCI_IDLE)
    else $error("warning not cleared on expiry");
  chk_warn_restart: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && new_warn_w |=> state_q == fci_pkg::FCI_WARN && code_q == $past(err_code_i) && warn_busy)
    else $error("warning not restarted");
  chk_rsvd_ignored: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && err_valid_i && err_code_i == 4'h0 && !warn_done |=> $stable(code_q))
    else $error("reserved code accepted");
  chk_script_rsvd: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && script_variant_i && state_q == fci_pkg::FCI_IDLE && err_code_i == 4'hc |=>
    state_q == fci_pkg::FCI_IDLE)
    else $error("script reserved code accepted");
  chk_config_invalid: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && config_mode_i |=> !fault_valid_o)
    else $error("fault valid in config mode");
  chk_addr_shown: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && state_d == fci_pkg::FCI_IDLE |=> lines_q == $past(bus_addr_i))
    else $error("address not shown when idle");
  chk_flash_lines: assert property (@(posedge clk_i) disable iff (srst_i)
    status_red_o |-> lines_q == code_q || lines_q == 4'h0)
    else $error("lines not flashing error code");
endmodule

// file: fci_cfg.svh
`ifndef FCI_CFG_SVH
`define FCI_CFG_SVH
// error code classes
`define FCI_SERIOUS_MIN 4'h1
`define FCI_SERIOUS_MAX 4'h5
`define FCI_WARN_MIN 4'h6
`define FCI_WARN_MAX 4'hf
// timing
// 64-bit so the one-minute product does not overflow 32-bit arithmetic
`define FCI_CLK_HZ 64'h7735940
`define FCI_WARN_TIME_S 60
`define FCI_WARN_CYCLES (`FCI_CLK_HZ * `FCI_WARN_TIME_S)
`define FCI_FLASH_TIME_MS 250
`define FCI_FLASH_CYCLES ((`FCI_CLK_HZ / 1000) * `FCI_FLASH_TIME_MS)
`define FCI_TMR_W 33
`endif

// file: fci_pkg.sv
package fci_pkg;
  typedef enum logic [1:0] {
    FCI_IDLE = 2'b00,
    FCI_WARN = 2'b01,
    FCI_SERIOUS = 2'b10
  } fci_state_t;
  // serial-protocol variant codes
  typedef enum logic [3:0] {
    FCI_RS_NONE = 4'h0,
    FCI_RS_SER_INIT = 4'h1,
    FCI_RS_NVM = 4'h2,
    FCI_RS_STACK = 4'h3,
    FCI_RS_FB_HW = 4'h4,
    FCI_RS_UNK_PROTO = 4'h5,
    FCI_RS_RSVD6 = 4'h6,
    FCI_RS_TX_OVF = 4'h7,
    FCI_RS_RX_OVF = 4'h8,
    FCI_RS_RX_TMO = 4'h9,
    FCI_RS_TX_FAIL = 4'ha,
    FCI_RS_PAR_FRM = 4'hb,
    FCI_RS_ADDR = 4'hc,
    FCI_RS_FB_CFG = 4'hd,
    FCI_RS_GENERAL = 4'he,
    FCI_RS_INTERNAL = 4'hf
  } fci_rs_code_t;
  // script variant codes
  typedef enum logic [3:0] {
    FCI_SC_NONE = 4'h0,
    FCI_SC_HW = 4'h1,
    FCI_SC_NVM = 4'h2,
    FCI_SC_INT_MEM = 4'h3,
    FCI_SC_FB_HW_ID = 4'h4,
    FCI_SC_SCRIPT = 4'h5,
    FCI_SC_RSVD6 = 4'h6,
    FCI_SC_TX_OVF = 4'h7,
    FCI_SC_RX_OVF = 4'h8,
    FCI_SC_TMO = 4'h9,
    FCI_SC_FB_GEN = 4'ha,
    FCI_SC_PAR_FRM = 4'hb,
    FCI_SC_RSVD12 = 4'hc,
    FCI_SC_RSVD13 = 4'hd,
    FCI_SC_FB_BUF = 4'he,
    FCI_SC_RSVD15 = 4'hf
  } fci_sc_code_t;
endpackage

// file: fci_timer.sv
`timescale 1ns/100ps
`include "fci_cfg.svh"
// restartable down-counter, done pulses when count reaches one
module fci_timer (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [`FCI_TMR_W-1:0] load_i,
  output logic busy_o,
  output logic done_o
);
  logic [`FCI_TMR_W-1:0] cnt_q;
  logic [`FCI_TMR_W-1:0] cnt_d;
  wire last_w = (cnt_q == `FCI_TMR_W'(1));
  assign busy_o = (cnt_q != '0);
  assign done_o = ce_i && last_w && !start_i && !stop_i;
  assign cnt_d = start_i ? load_i : (stop_i ? '0 : (busy_o ? cnt_q - `FCI_TMR_W'(1) : cnt_q));
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: fci_indicator_tb_top.sv
`timescale 1ns/100ps
module fci_indicator_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic script_variant_i = 1'b0;
  logic config_mode_i = 1'b0;
  logic err_valid_i = 1'b0;
  logic [3:0] err_code_i = 4'h0;
  logic [3:0] bus_addr_i = 4'h0;
  logic status_red_o;
  logic fault_valid_o;
  logic w8;
  logic w4;
  logic w2;
  logic w1;
  logic [5:0] exp_q[$];
  logic [5:0] note;
  int n_mismatch = 0;
  int tests_run = 0;
  int k;
  int v;

  always #4 clock_i = ~clock_i;

  fci_indicator #(
    .WARN_CYCLES(33'h14)
  ) DUT (
    .clk_i(clock_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .script_variant_i(script_variant_i),
    .config_mode_i(config_mode_i),
    .err_valid_i(err_valid_i),
    .err_code_i(err_code_i),
    .bus_addr_i(bus_addr_i),
    .status_red_o(status_red_o),
    .fault_valid_o(fault_valid_o),
    .weight_eight_indicator_o(w8),
    .weight_four_indicator_o(w4),
    .weight_two_indicator_o(w2),
    .weight_one_indicator_o(w1)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input string what, input logic [5:0] seen, input logic [5:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask

  task give_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // idle expectation shows the address driven in the same cycle
  task step(input logic ev, input logic [3:0] code, input logic red, input logic fv,
            input logic [3:0] lines);
    @(negedge clock_i);
    err_valid_i = ev;
    err_code_i = code;
    bus_addr_i = 4'($urandom);
    exp_q.push_back({red, fv, red ? lines : bus_addr_i});
    @(posedge clock_i);
    #2;
  endtask

  task pulse_reset();
    @(negedge clock_i);
    srst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    srst_i = 1'b0;
  endtask

  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  always @(posedge clock_i) begin
    #1;
    if (exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check("display", {1'b0, status_red_o, w8, w4, w2, w1}, {1'b0, note[5], note[3:0]});
      check("fault_valid", {5'h00, fault_valid_o}, {5'h00, note[4]});
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(42));
    repeat (4) @(negedge clock_i);
    srst_i = 1'b0;
    repeat (3) step(1'b0, 4'h0, 1'b0, 1'b0, 4'h0);
    step(1'b1, 4'h0, 1'b0, 1'b0, 4'h0);
    step(1'b1, 4'h6, 1'b0, 1'b0, 4'h0);
    script_variant_i = 1'b1;
    step(1'b1, 4'hc, 1'b0, 1'b0, 4'h0);
    step(1'b1, 4'hd, 1'b0, 1'b0, 4'h0);
    step(1'b1, 4'hf, 1'b0, 1'b0, 4'h0);
    for (k = 7; k <= 14; k++) begin
      if (k != 12 && k != 13) step(1'b1, 4'(k), 1'b1, 1'b1, 4'(k));
    end
    script_variant_i = 1'b0;
    for (k = 7; k <= 15; k++) step(1'b1, 4'(k), 1'b1, 1'b1, 4'(k));
    config_mode_i = 1'b1;
    step(1'b1, 4'h9, 1'b1, 1'b0, 4'h9);
    step(1'b0, 4'h0, 1'b1, 1'b0, 4'h9);
    config_mode_i = 1'b0;
    step(1'b1, 4'h6, 1'b1, 1'b1, 4'h9);
    ce_i = 1'b0;
    step(1'b1, 4'h3, 1'b1, 1'b1, 4'h9);
    ce_i = 1'b1;
    repeat (17) step(1'b0, 4'h0, 1'b1, 1'b1, 4'h9);
    repeat (2) step(1'b0, 4'h0, 1'b0, 1'b0, 4'h0);
    for (v = 0; v < 2; v++) begin
      script_variant_i = v[0];
      for (k = 1; k <= 5; k++) begin
        pulse_reset();
        step(1'b0, 4'h0, 1'b0, 1'b0, 4'h0);
        step(1'b1, 4'h8, 1'b1, 1'b1, 4'h8);
        step(1'b1, 4'(k), 1'b1, 1'b1, 4'(k));
        step(1'b1, 4'h7, 1'b1, 1'b1, 4'(k));
        step(1'b1, 4'(6 - k), 1'b1, 1'b1, 4'(k));
        repeat (5) step(1'b0, 4'h0, 1'b1, 1'b1, 4'(k));
      end
    end
    pulse_reset();
    repeat (2) step(1'b0, 4'h0, 1'b0, 1'b0, 4'h0);
    for (k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
    if (exp_q.size() > 0) n_mismatch++;
    give_verdict();
  end
endmodule
